// file: nand_bus_cycle.sv
`timescale 1ns/1ps
`include "nand_host_map.svh"
// one bus cycle on the pins: strobe low phase then high phase
module nand_bus_cycle (
  input  wire logic               clk,
  input  wire logic               srst,
  nand_cyc_if.phy                 cyc,
  input  wire nand_host_pkg::byte_t io_sync,
  output logic                    cle,
  output logic                    ale,
  output logic                    write_strobe_n,
  output logic                    read_strobe_n,
  output nand_host_pkg::byte_t    io_out,
  output logic                    io_oe
);
  import nand_host_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} ph_e;
  ph_e   ph_q, ph_d;
  cyc_e  kind_q, kind_d;
  byte_t wd_q, wd_d, rd_q, rd_d;
  logic [1:0] lc_q, lc_d;

  ////////////////////////////////////////////////////////////////////////
  // next phase
  always_comb begin
    ph_d   = ph_q;
    kind_d = kind_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    lc_d   = lc_q;
    case (ph_q)
      PH_IDLE: begin
        if (cyc.start) begin
          ph_d   = PH_LOW;
          lc_d   = 2'd0;
          kind_d = cyc.kind;
          wd_d   = cyc.wdata;
        end
      end
      PH_LOW: begin
        // read strobe held low three cycles so the byte has cleared
        // both input flops before it is taken
        if ((kind_q == CYC_DOUT) && (lc_q != 2'd2)) begin
          lc_d = lc_q + 2'd1;
        end else begin
          ph_d = PH_HIGH;
          if (kind_q == CYC_DOUT) rd_d = io_sync;
        end
      end
      PH_HIGH: ph_d = PH_IDLE;
      default: ph_d = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ph_q   <= PH_IDLE;
      kind_q <= CYC_CMD;
      wd_q   <= 8'h00;
      rd_q   <= 8'h00;
      lc_q   <= 2'd0;
    end else begin
      lc_q   <= lc_d;
      ph_q   <= ph_d;
      kind_q <= kind_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin levels: latches held over the whole cycle, rising edge latches
  // write strobe low with data driven
  // latch selects steer command or address
  assign cle            = (ph_q != PH_IDLE) && (kind_q == CYC_CMD);
  assign ale            = (ph_q != PH_IDLE) && (kind_q == CYC_ADDR);
  assign write_strobe_n = !((ph_q == PH_LOW) && (kind_q != CYC_DOUT));
  assign read_strobe_n  = !((ph_q == PH_LOW) && (kind_q == CYC_DOUT));
  assign io_oe          = (ph_q != PH_IDLE) && (kind_q != CYC_DOUT);
  assign io_out         = wd_q;
  assign cyc.done       = (ph_q == PH_HIGH);
  assign cyc.rdata      = rd_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // data held across strobe
  a_write_data_held: assert property (@(posedge clk) disable iff (srst)
    !write_strobe_n |-> io_oe ##1 (write_strobe_n && io_oe &&
    $stable(io_out)))
    else $error("data not held through write strobe");
  a_latch_exclusive: assert property (@(posedge clk) disable iff (srst)
    !(cle && ale)) else $error("both latch selects high");
  a_strobes_exclusive: assert property (@(posedge clk) disable iff (srst)
    !(!write_strobe_n && !read_strobe_n))
    else $error("both strobes low");
  a_cycle_length: assert property (@(posedge clk) disable iff (srst)
    (ph_q == PH_IDLE && cyc.start && cyc.kind != CYC_DOUT) |=> ##1 cyc.done)
    else $error("bus cycle not two phases");
  a_read_length: assert property (@(posedge clk) disable iff (srst)
    (ph_q == PH_IDLE && cyc.start && cyc.kind == CYC_DOUT) |=> ##3 cyc.done)
    else $error("read cycle not four phases");
  c_read_cycle: cover property (@(posedge clk) !read_strobe_n);
  c_cmd_cycle: cover property (@(posedge clk) cle && !write_strobe_n);
endmodule : nand_bus_cycle

// file: nand_cyc_if.sv
`timescale 1ns/1ps
interface nand_cyc_if;
  import nand_host_pkg::*;
  logic  start;
  cyc_e  kind;
  byte_t wdata;
  logic  done;
  byte_t rdata;
  modport seq (output start, output kind, output wdata,
               input done, input rdata);
  modport phy (input start, input kind, input wdata,
               output done, output rdata);
endinterface : nand_cyc_if

// file: nand_dev_model.sv
`timescale 1ns/1ps
// behavioural flash array as seen from its pins
module nand_dev_model #(
  parameter int BUSY_CYC = 40
) (
  input  wire logic        clk,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        wp_n,
  input  wire logic [7:0]  io,
  output logic      [7:0]  dev_q,
  output logic             dev_oe,
  output logic             rb,
  output logic      [7:0]  first_cmd,
  output logic      [7:0]  last_cmd,
  output int               addr_cnt,
  output logic      [31:0] addr_w,
  output int               erase_cnt
);
  logic [7:0]  page [0:2111];
  logic [11:0] col;
  int          busy_cnt;
  // one page register of 2112 columns
  initial begin
    for (int i = 0; i < 2112; i++) page[i] = i[7:0];
    {dev_q, dev_oe, first_cmd, last_cmd, addr_w, col} = '0;
    {addr_cnt, erase_cnt, busy_cnt} = '0;
  end
  // open-drain ready, low while the array works
  assign rb = (busy_cnt == 0);
  // busy countdown
  always @(posedge clk) if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  // byte latched at write strobe rise
  always @(posedge we_n) begin
    if (cle) begin
      // while busy only reset and status
      if (busy_cnt == 0 || io == 8'hff || io == 8'h70) begin
        last_cmd <= io;
        case (io)
          8'h30, 8'h35: busy_cnt <= BUSY_CYC;
          8'h10, 8'h15: if (wp_n) busy_cnt <= BUSY_CYC;
          8'hd0: if (wp_n) begin
            busy_cnt  <= BUSY_CYC;
            erase_cnt <= erase_cnt + 1;
          end
          // setup codes open a new sequence
          8'h00, 8'h05, 8'h60, 8'h70, 8'h80, 8'h85, 8'h90, 8'hff: begin
            first_cmd <= io;
            addr_cnt  <= 0;
            addr_w    <= '0;
          end
          default: ;
        endcase
        if (io == 8'hff) busy_cnt <= 0;
      end
    end else if (ale) begin
      if (addr_cnt < 4) addr_w[8*addr_cnt +: 8] <= io;
      if (addr_cnt == 1) col <= {io[3:0], addr_w[7:0]};
      if (addr_cnt < 4) addr_cnt <= addr_cnt + 1;
    end else begin
      page[col] <= io;
      col       <= col + 1;
    end
  end
  // read strobe fall gives byte and steps column
  always @(negedge re_n) begin
    dev_q  <= page[col];
    dev_oe <= 1'b1;
    col    <= col + 1;
  end
  // output released as the read strobe rises
  always @(posedge re_n) dev_oe <= 1'b0;
endmodule : nand_dev_model

// file: nand_host_ctrl.sv
`timescale 1ns/1ps
`include "nand_host_map.svh"
module nand_host_ctrl (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 SRST_IN,
  input  wire logic                 REQ_VALID_IN,
  output logic                      REQ_READY_OUT,
  input  wire nand_host_pkg::op_e   REQ_OP_IN,
  input  wire nand_host_pkg::col_t  REQ_COL_IN,
  input  wire nand_host_pkg::row_t  REQ_ROW_IN,
  input  wire nand_host_pkg::byte_t REQ_WDATA_IN,
  input  wire logic                 WRITE_ENABLE_IN,
  output logic                      RDATA_VALID_OUT,
  output nand_host_pkg::byte_t      RDATA_OUT,
  output logic                      REJECT_OUT,
  output logic                      BUSY_OUT,
  output logic                      CHIP_SELECT_N_OUT,
  output logic                      CMD_LATCH_OUT,
  output logic                      ADDR_LATCH_OUT,
  output logic                      WRITE_STROBE_N_OUT,
  output logic                      READ_STROBE_N_OUT,
  output logic                      WRITE_GUARD_N_OUT,
  input  wire nand_host_pkg::byte_t IO_IN,
  output nand_host_pkg::byte_t      IO_OUT,
  output logic                      IO_OE_OUT,
  input  wire logic                 READY_BUSY_IN
);
  import nand_host_pkg::*;

  // command plan for an op: which bytes in which order
  function automatic logic is_busy_op(input op_e op);
    is_busy_op = (op == OP_READ) || (op == OP_COPY_READ) ||
                 (op == OP_PROGRAM) || (op == OP_CACHE_PROG) ||
                 (op == OP_COPY_PROG) || (op == OP_ERASE) ||
                 (op == OP_PROG_CONFIRM) || (op == OP_CACHE_CONFIRM) ||
                 (op == OP_RESET);
  endfunction : is_busy_op

  function automatic logic is_array_op(input op_e op);
    is_array_op = (op == OP_PROGRAM) || (op == OP_CACHE_PROG) ||
                  (op == OP_COPY_PROG) || (op == OP_ERASE);
  endfunction : is_array_op

  // first command byte; only codes from the defined set
  function automatic byte_t first_code(input op_e op);
    case (op)
      OP_READ, OP_COPY_READ: first_code = `CMD_READ_SETUP;
      OP_READ_ID:            first_code = `CMD_READ_ID;
      OP_RESET:              first_code = `CMD_RESET;
      OP_PROGRAM,
      OP_CACHE_PROG:         first_code = `CMD_PROG_SETUP;
      OP_COPY_PROG,
      OP_RAND_IN:            first_code = `CMD_COPY_PROG;
      OP_ERASE:              first_code = `CMD_ERASE_SETUP;
      OP_RAND_OUT:           first_code = `CMD_RAND_OUT;
      default:               first_code = `CMD_STATUS;
    endcase
  endfunction : first_code

  function automatic byte_t second_code(input op_e op);
    case (op)
      OP_READ:       second_code = `CMD_READ_CONFIRM;
      OP_COPY_READ:  second_code = `CMD_COPY_READ;
      OP_CACHE_PROG,
      OP_CACHE_CONFIRM: second_code = `CMD_CACHE_CONFIRM;
      OP_ERASE:      second_code = `CMD_ERASE_CONFIRM;
      OP_RAND_OUT:   second_code = `CMD_RAND_OUT_CONF;
      default:       second_code = `CMD_PROG_CONFIRM;
    endcase
  endfunction : second_code

  typedef enum logic [2:0] {
    S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WAIT_WB, S_ONE
  } st_e;

  ////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  logic  rb_meta_q, rb_q;
  byte_t io_meta_q, io_sync_q;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      rb_meta_q <= 1'b1;
      rb_q      <= 1'b1;
      io_meta_q <= 8'h00;
      io_sync_q <= 8'h00;
    end else begin
      rb_meta_q <= READY_BUSY_IN;
      rb_q      <= rb_meta_q;
      io_meta_q <= IO_IN;
      io_sync_q <= io_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus cycle engine
  nand_cyc_if cyc ();
  nand_bus_cycle u_cycle (
    .clk            (CORE_CLK_IN),
    .srst           (SRST_IN),
    .cyc            (cyc),
    .io_sync        (io_sync_q),
    .cle            (CMD_LATCH_OUT),
    .ale            (ADDR_LATCH_OUT),
    .write_strobe_n (WRITE_STROBE_N_OUT),
    .read_strobe_n  (READ_STROBE_N_OUT),
    .io_out         (IO_OUT),
    .io_oe          (IO_OE_OUT)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer state
  st_e        st_q, st_d;
  op_e        op_q, op_d;
  col_t       col_q, col_d;
  row_t       row_q, row_d;
  byte_t      wd_q, wd_d;
  logic [1:0] ai_q, ai_d;
  logic [2:0] wb_q, wb_d;
  logic       busy_q, busy_d;
  logic       rv_q, rv_d;
  byte_t      rdata_q, rdata_d;
  logic       rej_q, rej_d;
  logic       go;
  logic       allowed;
  logic [1:0] last_ai;

  // new ops only when ready, except reset and status
  assign allowed = !busy_q || (REQ_OP_IN == OP_RESET) ||
                   (REQ_OP_IN == OP_STATUS);
  assign REQ_READY_OUT = (st_q == S_IDLE);
  assign go = REQ_VALID_IN && REQ_READY_OUT && allowed;
  // four cycles from col; erase starts at row cycles
  assign last_ai = 2'd3;

  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    col_d   = col_q;
    row_d   = row_q;
    wd_d    = wd_q;
    ai_d    = ai_q;
    wb_d    = wb_q;
    busy_d  = busy_q;
    rv_d    = 1'b0;
    rdata_d = rdata_q;
    rej_d   = REQ_VALID_IN && REQ_READY_OUT && !allowed;
    cyc.start = 1'b0;
    cyc.kind  = CYC_CMD;
    cyc.wdata = first_code(op_q);
    // ready seen again ends the tracked busy period
    if (busy_q && rb_q && (st_q != S_WAIT_WB)) busy_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (go) begin
          op_d  = REQ_OP_IN;
          col_d = REQ_COL_IN;
          row_d = REQ_ROW_IN;
          wd_d  = REQ_WDATA_IN;
          ai_d  = (REQ_OP_IN == OP_ERASE) ? 2'd2 : 2'd0;
          if ((REQ_OP_IN == OP_DATA_OUT) || (REQ_OP_IN == OP_DATA_IN))
            st_d = S_ONE;
          else if ((REQ_OP_IN == OP_PROG_CONFIRM) ||
                   (REQ_OP_IN == OP_CACHE_CONFIRM))
            st_d = S_CMD2;
          else
            st_d = S_CMD1;
        end
      end
      // first command cycle; the only command cycle for reset, status, id
      S_CMD1: begin
        cyc.start = 1'b1;
        if (cyc.done) begin
          if (op_q == OP_RESET || op_q == OP_STATUS) st_d = S_WAIT_WB;
          else if (op_q == OP_READ_ID) st_d = S_ADDR;
          else st_d = S_ADDR;
          if (op_q == OP_STATUS) st_d = S_IDLE;
          if (op_q == OP_RESET) busy_d = 1'b1;
          if (op_q == OP_RESET) wb_d = 3'd0;
        end
      end
      // column low, column high, row low, row high
      S_ADDR: begin
        cyc.start = 1'b1;
        cyc.kind  = CYC_ADDR;
        case (ai_q)
          2'd0:    cyc.wdata = col_q[7:0];
          2'd1:    cyc.wdata = {4'h0, col_q[11:8]};
          2'd2:    cyc.wdata = row_q[7:0];
          default: cyc.wdata = row_q[15:8];
        endcase
        if (op_q == OP_READ_ID) cyc.wdata = 8'h00;
        if (cyc.done) begin
          ai_d = ai_q + 2'd1;
          // column change sends only column cycles
          if ((op_q == OP_READ_ID) ||
              ((op_q == OP_RAND_IN) && (ai_q == 2'd1))) st_d = S_IDLE;
          else if ((op_q == OP_RAND_OUT) && (ai_q == 2'd1)) st_d = S_CMD2;
          else if ((op_q == OP_COPY_PROG) && (ai_q == last_ai))
            st_d = S_CMD2;
          else if (ai_q == last_ai)
            st_d = (op_q == OP_PROGRAM || op_q == OP_CACHE_PROG) ?
                   S_IDLE : S_CMD2;
        end
      end
      S_CMD2: begin
        cyc.start = 1'b1;
        cyc.wdata = second_code(op_q);
        if (cyc.done) begin
          busy_d = is_busy_op(op_q);
          wb_d   = 3'd0;
          st_d   = busy_d ? S_WAIT_WB : S_IDLE;
        end
      end
      // allow the device its busy delay before sampling ready
      S_WAIT_WB: begin
        wb_d = wb_q + 3'd1;
        if (wb_q == 3'(`WB_CYCLES + 2)) st_d = S_IDLE;
      end
      // one data byte per strobe; data input or data output cycle
      S_ONE: begin
        cyc.start = 1'b1;
        cyc.kind  = (op_q == OP_DATA_OUT) ? CYC_DOUT : CYC_DIN;
        cyc.wdata = wd_q;
        if (cyc.done) begin
          st_d    = S_IDLE;
          rv_d    = (op_q == OP_DATA_OUT);
          rdata_d = cyc.rdata;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      st_q    <= S_IDLE;
      op_q    <= OP_STATUS;
      col_q   <= 12'h000;
      row_q   <= 16'h0000;
      wd_q    <= 8'h00;
      ai_q    <= 2'd0;
      wb_q    <= 3'd0;
      busy_q  <= 1'b0;
      rv_q    <= 1'b0;
      rdata_q <= 8'h00;
      rej_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      col_q   <= col_d;
      row_q   <= row_d;
      wd_q    <= wd_d;
      ai_q    <= ai_d;
      wb_q    <= wb_d;
      busy_q  <= busy_d;
      rv_q    <= rv_d;
      rdata_q <= rdata_d;
      rej_q   <= rej_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign RDATA_VALID_OUT   = rv_q;
  assign RDATA_OUT         = rdata_q;
  assign REJECT_OUT        = rej_q;
  assign BUSY_OUT          = busy_q;
  assign CHIP_SELECT_N_OUT = 1'b0;
  // guard low unless program or erase is allowed
  assign WRITE_GUARD_N_OUT = WRITE_ENABLE_IN;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // no command but reset or status while busy
  a_busy_gate: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (busy_q && CMD_LATCH_OUT && !WRITE_STROBE_N_OUT) |->
    (IO_OUT == `CMD_RESET || IO_OUT == `CMD_STATUS))
    else $error("command other than reset or status sent while busy");
  a_defined_codes: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (CMD_LATCH_OUT && !WRITE_STROBE_N_OUT) |->
    (IO_OUT inside {8'h00, 8'h30, 8'h35, 8'h90, 8'hff, 8'h80, 8'h10,
     8'h15, 8'h85, 8'h60, 8'hd0, 8'h05, 8'he0, 8'h70}))
    else $error("undefined command code sent");
  // second column cycle keeps upper nibble low
  a_col_high_zero: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (st_q == S_ADDR && ai_q == 2'd1 &&
    ADDR_LATCH_OUT && !WRITE_STROBE_N_OUT && op_q != OP_READ_ID) |->
    IO_OUT[7:4] == 4'h0)
    else $error("reserved column bits not low");
  a_erase_rows: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (st_q == S_CMD1 && op_q == OP_ERASE && cyc.done)
    |=> ai_q == 2'd2) else $error("erase sent column cycles");
  a_read_confirm: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (st_q == S_CMD2 && op_q == OP_READ &&
    !WRITE_STROBE_N_OUT) |-> IO_OUT == `CMD_READ_CONFIRM)
    else $error("wrong read confirm");
  a_erase_busy: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (st_q == S_CMD2 && op_q == OP_ERASE && cyc.done)
    |=> busy_q) else $error("erase did not set busy");
  // read byte returned four cycles after its strobe falls
  a_read_return: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (st_q == S_ONE && op_q == OP_DATA_OUT &&
    $fell(READ_STROBE_N_OUT)) |-> ##4 RDATA_VALID_OUT)
    else $error("read byte not returned");
  // ready seen while idle ends busy on the next edge
  a_ready_ends: assert property (@(posedge CORE_CLK_IN)
    disable iff (SRST_IN) (busy_q && rb_q && st_q == S_IDLE) |=> !busy_q)
    else $error("busy held after ready");
  c_erase: cover property (@(posedge CORE_CLK_IN) st_q == S_CMD2 &&
    op_q == OP_ERASE && cyc.done);
  c_read_data: cover property (@(posedge CORE_CLK_IN) RDATA_VALID_OUT);
  c_reject: cover property (@(posedge CORE_CLK_IN) REJECT_OUT);
endmodule : nand_host_ctrl

// file: nand_host_ctrl_tb.sv
`timescale 1ns/1ps
module nand_host_ctrl_tb;
  import nand_host_pkg::*;
  typedef struct {op_e op; byte_t f; byte_t l; int n;} row_s;
  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        req_valid = 1'b0;
  op_e         req_op    = OP_STATUS;
  col_t        req_col   = '0;
  row_t        req_row   = '0;
  byte_t       req_wdata = '0;
  logic        wr_en     = 1'b1;
  logic        ready, rd_valid, reject, busy, cs_n, cle, ale, we_n, re_n;
  logic        wp_n, io_oe, rb, dev_oe;
  byte_t       rdata, io_out, io_bus, dev_q, first_cmd, last_cmd;
  logic [31:0] addr_w;
  int          addr_cnt, erase_cnt;
  int          miscompares = 0;
  int          cmp_count   = 0;
  row_s        rows [13];
  // clock of 50 ns
  always #25 clk = ~clk;
  // shared bus level; undriven lines toggle every half cycle
  assign io_bus = io_oe ? io_out : dev_oe ? dev_q : (8'h5a ^ {8{clk}});
  nand_host_ctrl nand_host_ctrl_inst (
    .CORE_CLK_IN(clk), .SRST_IN(srst), .REQ_VALID_IN(req_valid),
    .REQ_READY_OUT(ready), .REQ_OP_IN(req_op), .REQ_COL_IN(req_col),
    .REQ_ROW_IN(req_row), .REQ_WDATA_IN(req_wdata),
    .WRITE_ENABLE_IN(wr_en), .RDATA_VALID_OUT(rd_valid),
    .RDATA_OUT(rdata), .REJECT_OUT(reject), .BUSY_OUT(busy),
    .CHIP_SELECT_N_OUT(cs_n), .CMD_LATCH_OUT(cle), .ADDR_LATCH_OUT(ale),
    .WRITE_STROBE_N_OUT(we_n), .READ_STROBE_N_OUT(re_n),
    .WRITE_GUARD_N_OUT(wp_n), .IO_IN(io_bus), .IO_OUT(io_out),
    .IO_OE_OUT(io_oe), .READY_BUSY_IN(rb));
  nand_dev_model nand_dev_model_inst (
    .clk(clk), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io(io_bus), .dev_q(dev_q), .dev_oe(dev_oe), .rb(rb),
    .first_cmd(first_cmd), .last_cmd(last_cmd), .addr_cnt(addr_cnt),
    .addr_w(addr_w), .erase_cnt(erase_cnt));
  ////////////////////////////////////////////////////////////////////////
  // address bytes the device should hold after an op
  function automatic logic [31:0] exp_addr(input op_e op, input col_t c,
                                           input row_t r);
    case (op)
      OP_ERASE:                return {16'h0, r};
      OP_RAND_IN, OP_RAND_OUT: return {16'h0, 4'h0, c};
      OP_READ_ID, OP_RESET, OP_STATUS: return 32'h0;
      default:                 return {r, 4'h0, c};
    endcase
  endfunction : exp_addr
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic cmp_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val
  task automatic hang(input string nm);
    miscompares++;
    $display("unexpected wait %s: expected done seen timeout", nm);
    report_and_stop();
  endtask : hang
  // waits for idle sequencer, and with full also for a ready device
  task automatic wait_idle(input bit full);
    int n;
    n = 0;
    @(posedge clk) #1;
    while (!(ready === 1'b1 && (!full || (busy === 1'b0 && rb === 1'b1))))
    begin
      @(posedge clk) #1;
      n++;
      if (n > 500) hang("idle");
    end
  endtask : wait_idle
  // request held until the edge that takes it
  task automatic issue(input op_e op, input col_t c, input row_t r,
                       input byte_t d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_col   <= c;
    req_row   <= r;
    req_wdata <= d;
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk) #1;
      n++;
      if (n > 500) hang("ready");
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : issue
  task automatic read_byte(input byte_t e);
    int n;
    n = 0;
    issue(OP_DATA_OUT, '0, '0, '0);
    do begin
      @(posedge clk) #1;
      n++;
      if (n > 20) hang("rdata");
    end while (rd_valid !== 1'b1);
    cmp_val("rdata", e, rdata);
  endtask : read_byte
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int seen;
    rows[0]  = '{OP_READ, 8'h00, 8'h30, 4};
    rows[1]  = '{OP_COPY_READ, 8'h00, 8'h35, 4};
    rows[2]  = '{OP_READ_ID, 8'h90, 8'h90, 1};
    rows[3]  = '{OP_RESET, 8'hff, 8'hff, 0};
    rows[4]  = '{OP_PROGRAM, 8'h80, 8'h80, 4};
    rows[5]  = '{OP_PROG_CONFIRM, 8'h80, 8'h10, 4};
    rows[6]  = '{OP_CACHE_PROG, 8'h80, 8'h80, 4};
    rows[7]  = '{OP_CACHE_CONFIRM, 8'h80, 8'h15, 4};
    rows[8]  = '{OP_COPY_PROG, 8'h85, 8'h10, 4};
    rows[9]  = '{OP_ERASE, 8'h60, 8'hd0, 2};
    rows[10] = '{OP_RAND_IN, 8'h85, 8'h85, 2};
    rows[11] = '{OP_RAND_OUT, 8'h05, 8'he0, 2};
    rows[12] = '{OP_STATUS, 8'h70, 8'h70, 0};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk) #1;
    cmp_val("idle", 7'b1000110, {ready, busy, cle, ale, we_n, re_n, io_oe});
    cmp_val("select", 0, cs_n);
    for (int i = 0; i < 13; i++) begin
      issue(rows[i].op, 12'h83e, 16'h1234, 8'h00);
      wait_idle(1'b1);
      cmp_val("first", rows[i].f, first_cmd);
      cmp_val("last", rows[i].l, last_cmd);
      cmp_val("count", rows[i].n, addr_cnt);
      cmp_val("addr", exp_addr(rows[i].op, 12'h83e, 16'h1234), addr_w);
      $display("test op %s done", rows[i].op.name());
    end
    cmp_val("erases", 1, erase_cnt);
    // refusal while busy, then status and reset taken
    issue(OP_READ, 12'h0, 16'h7, 8'h00);
    n = 0;
    while (busy !== 1'b1) begin
      @(posedge clk) #1;
      n++;
      if (n > 100) hang("busy");
    end
    issue(OP_PROGRAM, 12'h0, 16'h9, 8'h00);
    seen = 0;
    repeat (3) begin
      #1;
      if (reject === 1'b1) seen = 1;
      @(posedge clk);
    end
    cmp_val("reject", 1, seen);
    cmp_val("refused", 8'h30, last_cmd);
    issue(OP_STATUS, '0, '0, '0);
    wait_idle(1'b0);
    cmp_val("status", 8'h70, last_cmd);
    issue(OP_RESET, '0, '0, '0);
    wait_idle(1'b1);
    cmp_val("reset", 8'hff, last_cmd);
    $display("test busy done");
    // data into the spare area, read back by column change
    issue(OP_PROGRAM, 12'h83e, 16'h2, 8'h00);
    issue(OP_DATA_IN, '0, '0, 8'ha5);
    issue(OP_DATA_IN, '0, '0, 8'h3c);
    issue(OP_PROG_CONFIRM, '0, '0, '0);
    wait_idle(1'b1);
    cmp_val("confirm", 8'h10, last_cmd);
    issue(OP_RAND_OUT, 12'h83e, 16'h0, 8'h00);
    wait_idle(1'b1);
    read_byte(8'ha5);
    read_byte(8'h3c);
    $display("test data done");
    // guard low blocks erase
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk) #1;
    cmp_val("guard", 0, wp_n);
    issue(OP_ERASE, '0, 16'h40, 8'h00);
    wait_idle(1'b1);
    cmp_val("guarded", 1, erase_cnt);
    wr_en <= 1'b1;
    $display("test guard done");
    // second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk) #1;
    cmp_val("idle", 7'b1000110, {ready, busy, cle, ale, we_n, re_n, io_oe});
    $display("test reset done");
    report_and_stop();
  end
endmodule : nand_host_ctrl_tb

// file: nand_host_map.svh
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH
// command codes
`define CMD_READ_SETUP    8'h00
`define CMD_READ_CONFIRM  8'h30
`define CMD_COPY_READ     8'h35
`define CMD_READ_ID       8'h90
`define CMD_RESET         8'hff
`define CMD_PROG_SETUP    8'h80
`define CMD_PROG_CONFIRM  8'h10
`define CMD_CACHE_CONFIRM 8'h15
`define CMD_COPY_PROG     8'h85
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_CONFIRM 8'hd0
`define CMD_RAND_OUT      8'h05
`define CMD_RAND_OUT_CONF 8'he0
`define CMD_STATUS        8'h70
// geometry
`define PAGE_BYTES        12'h840
`define SPARE_FIRST_COL   12'h800
`define SPARE_LAST_COL    12'h83f
`define BLOCK_COUNT       11'h400
// strobe timing: one phase is one 50 ns cycle, three cycles for the read strobe low phase
`define CLK_PERIOD_NS     50
`define WB_MAX_NS         100
`define WB_CYCLES         ((`WB_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: nand_host_pkg.sv
package nand_host_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_COPY_READ, OP_READ_ID, OP_RESET, OP_PROGRAM, OP_CACHE_PROG,
    OP_COPY_PROG, OP_ERASE, OP_RAND_IN, OP_RAND_OUT, OP_STATUS, OP_DATA_OUT,
    OP_DATA_IN, OP_PROG_CONFIRM, OP_CACHE_CONFIRM
  } op_e;
  typedef enum logic [1:0] {
    CYC_CMD, CYC_ADDR, CYC_DIN, CYC_DOUT
  } cyc_e;
  typedef logic [11:0] col_t;
  typedef logic [15:0] row_t;
  typedef logic [7:0]  byte_t;
endpackage : nand_host_pkg
